// file: test/irf_properties.sv
// concurrent checks on the request flag block ports
`timescale 1ns/1ps
module irf_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic timer_a_overflow,
  input wire logic timer_g_event,
  input wire logic sleep_exec,
  input wire logic direct_mode_transfer,
  input wire logic conversion_in_progress,
  input wire logic [7:0] pin_request_flags,
  input wire logic [7:0] peripheral_request_flags,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // reserved places: pin bit 5 stuck high, peripheral bit 5 never set
  rsvd_bits_a: assert property (
    pin_request_flags[5] && !peripheral_request_flags[5]) else $error("reserved bit wrong");
  // event sampled at edge k shows on the flag view two samples later
  timer_a_set_a: assert property (
    timer_a_overflow |-> ##2 pin_request_flags[7]) else $error("timer a flag not set");
  timer_g_set_a: assert property (
    timer_g_event |-> ##2 peripheral_request_flags[4]) else $error("timer g flag not set");
  adc_done_a: assert property (
    $fell(conversion_in_progress) |-> ##2 peripheral_request_flags[6])
    else $error("adc flag not set");
  // a flag may only rise from its own cause, never from a bus write
  direct_cause_a: assert property (
    $rose(peripheral_request_flags[7]) |-> $past(sleep_exec, 2) && $past(direct_mode_transfer, 2))
    else $error("direct flag without cause");
  tmr_a_cause_a: assert property (
    $rose(pin_request_flags[7]) |-> $past(timer_a_overflow, 2)) else $error("timer a flag rose");
  // flags only fall after a completed bus write, never on their own
  pin_sticky_a: assert property (
    |($past(pin_request_flags) & ~pin_request_flags) |-> $past(s_axi_bvalid))
    else $error("pin flag fell without write");
  per_sticky_a: assert property (
    |($past(peripheral_request_flags) & ~peripheral_request_flags) |-> $past(s_axi_bvalid))
    else $error("peripheral flag fell without write");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");

  cover property (irq[*2]);
  cover property ($rose(peripheral_request_flags[7]));
  cover property ($fell(pin_request_flags[3]));
endmodule : irf_properties

bind irf_top irf_properties irf_properties_i (.clk, .rstn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_bvalid, .timer_a_overflow, .timer_g_event, .sleep_exec,
  .direct_mode_transfer, .conversion_in_progress, .pin_request_flags,
  .peripheral_request_flags, .irq);

// file: test/irf_top_test.sv
// self-checking bench for the request flag block
`timescale 1ns/1ps
`include "irf_params.svh"
module irf_top_test import irf_pkg::*; ;
  logic clk, rstn, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  irf_resp_t s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  irf_pins_t ext_pins;
  logic timer_a_overflow, timer_g_event, timer_fh_event, timer_fl_event, timer_c_event;
  logic evt_counter_overflow, sleep_exec, direct_mode_transfer, conversion_in_progress;
  irf_flags_t pin_request_flags, peripheral_request_flags, exp_pin, exp_per;
  logic [15:0] exp_st;
  int error_cnt, checks;

  irf_top irf_top_i (.clk, .rstn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_pins, .timer_a_overflow, .timer_g_event,
    .timer_fh_event, .timer_fl_event, .timer_c_event, .evt_counter_overflow, .sleep_exec,
    .direct_mode_transfer, .conversion_in_progress, .pin_request_flags,
    .peripheral_request_flags, .irq);

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // peripheral flags after one event cycle; s = {adc level, a, g, fh, fl, c, evt, sleep, dmt}
  function automatic irf_flags_t per_next(irf_flags_t f, logic [8:0] s, logic en, logic prev);
    return f | {s[1] & s[0] & en, prev & !s[8], 1'b0, s[6:2]};
  endfunction : per_next

  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // bready stays high, so the first edge with bvalid high is the response handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input irf_resp_t er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    if (!s_axi_bvalid) begin
      chk(0, 1, "write timeout");
      stop_test();
    end
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input irf_resp_t er,
                    input string what);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    if (!s_axi_rvalid) begin
      chk(0, 1, "read timeout");
      stop_test();
    end
    chk(s_axi_rdata, e, what);
    chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
  endtask : rd

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    {ext_pins, timer_a_overflow, timer_g_event, timer_fh_event, timer_fl_event} = '0;
    {timer_c_event, evt_counter_overflow, sleep_exec, direct_mode_transfer} = '0;
    conversion_in_progress = 1'b0;
    seed = 32'hd036bf8c;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`IRF_OFF_PIN_FLAGS, 32'h20, `IRF_RESP_OKAY, "pin reset");
    rd(`IRF_OFF_PERIPH_FLAGS, 32'h0, `IRF_RESP_OKAY, "periph reset");
    rd(8'h1c, 32'h0, `IRF_RESP_SLVERR, "unmapped read");
    wr(8'h1c, 32'hff, `IRF_RESP_SLVERR);
    // writing ones must not set anything, reserved pin bit keeps reading one
    wr(`IRF_OFF_PIN_FLAGS, 32'hff, `IRF_RESP_OKAY);
    wr(`IRF_OFF_PERIPH_FLAGS, 32'hdf, `IRF_RESP_OKAY);
    rd(`IRF_OFF_PIN_FLAGS, 32'h20, `IRF_RESP_OKAY, "pin write ones");
    rd(`IRF_OFF_PERIPH_FLAGS, 32'h0, `IRF_RESP_OKAY, "periph write ones");
    // pins 4,3,1,0 designated, event pin not; pin 4 on falling edge, rest rising
    wr(`IRF_OFF_PIN_CONFIG, 32'h0f1b, `IRF_RESP_OKAY);
    rd(`IRF_OFF_PIN_CONFIG, 32'h0f1b, `IRF_RESP_OKAY, "config");
    ext_pins <= 5'h1f;
    repeat (3) @(posedge clk);
    rd(`IRF_OFF_PIN_FLAGS, 32'h2b, `IRF_RESP_OKAY, "rising pins");
    ext_pins <= 5'h00;
    repeat (3) @(posedge clk);
    rd(`IRF_OFF_PIN_FLAGS, 32'h3b, `IRF_RESP_OKAY, "falling pin");
    wr(`IRF_OFF_PIN_CONFIG, 32'h0f1f, `IRF_RESP_OKAY);
    ext_pins <= 5'h04;
    repeat (3) @(posedge clk);
    rd(`IRF_OFF_PIN_FLAGS, 32'h3f, `IRF_RESP_OKAY, "event pin");
    wr(`IRF_OFF_PIN_FLAGS, 32'heb, `IRF_RESP_OKAY);
    rd(`IRF_OFF_PIN_FLAGS, 32'h2b, `IRF_RESP_OKAY, "partial clear");
    exp_pin = 8'h0b;
    exp_per = 8'h00;
    exp_st = 16'h001f;
    // random event bursts with random clears; direct transfer enabled for the second half
    for (int i = 0; i < 24; i++) begin
      if (i == 12) wr(`IRF_OFF_SYS_CTRL_TWO, 32'h1, `IRF_RESP_OKAY);
      seed = xs(seed);
      {timer_a_overflow, timer_g_event, timer_fh_event, timer_fl_event, timer_c_event,
        evt_counter_overflow, sleep_exec, direct_mode_transfer} <= seed[7:0];
      conversion_in_progress <= seed[8];
      exp_per = per_next(exp_per, seed[8:0], i >= 12, conversion_in_progress);
      exp_st |= {per_next(8'h00, seed[8:0], i >= 12, conversion_in_progress), seed[7], 7'h0};
      exp_pin |= {seed[7], 7'h0};
      @(posedge clk);
      {timer_a_overflow, timer_g_event, timer_fh_event, timer_fl_event, timer_c_event,
        evt_counter_overflow, sleep_exec, direct_mode_transfer} <= 8'h00;
      wr(`IRF_OFF_PERIPH_FLAGS, {24'h0, seed[23:16] & 8'hdf}, `IRF_RESP_OKAY);
      wr(`IRF_OFF_PIN_FLAGS, {24'h0, seed[31:24]}, `IRF_RESP_OKAY);
      exp_per &= seed[23:16];
      exp_pin &= seed[31:24];
      rd(`IRF_OFF_PIN_FLAGS, {24'h0, exp_pin | 8'h20}, `IRF_RESP_OKAY, "pin");
      rd(`IRF_OFF_PERIPH_FLAGS, {24'h0, exp_per}, `IRF_RESP_OKAY, "periph");
    end
    // status read clears, mask gates the interrupt, flags stay put
    rd(`IRF_OFF_IRQ_STATUS, {16'h0, exp_st}, `IRF_RESP_OKAY, "status");
    rd(`IRF_OFF_IRQ_STATUS, 32'h0, `IRF_RESP_OKAY, "status cleared");
    wr(`IRF_OFF_IRQ_MASK, 32'h0100, `IRF_RESP_OKAY);
    rd(`IRF_OFF_IRQ_MASK, 32'h0100, `IRF_RESP_OKAY, "mask");
    timer_g_event <= 1'b1;
    @(posedge clk);
    timer_g_event <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "masked irq");
    evt_counter_overflow <= 1'b1;
    @(posedge clk);
    evt_counter_overflow <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(`IRF_OFF_IRQ_STATUS, 32'h1100, `IRF_RESP_OKAY, "status events");
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd(`IRF_OFF_PERIPH_FLAGS, {24'h0, exp_per | 8'h11}, `IRF_RESP_OKAY, "sticky");
    stop_test();
  end
endmodule : irf_top_test

// file: verilog/irf_edge_detect.sv
// per-line edge detector with edge select and designation gate
`timescale 1ns/1ps
module irf_edge_detect #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] level,
  input wire logic [W-1:0] rising_sel,
  input wire logic [W-1:0] designated,
  output logic [W-1:0] evt
);
  logic [W-1:0] prev;
  logic primed;

  // history always follows the line, so designating a pin later gives no false edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev <= '0;
      primed <= 1'b0;
    end else begin
      prev <= level;
      primed <= 1'b1;
    end
  end

  // first cycle after reset has no valid history and is masked
  always_comb begin
    for (int i = 0; i < W; i++) begin
      evt[i] = primed & designated[i] &
               (rising_sel[i] ? (level[i] & ~prev[i]) : (~level[i] & prev[i]));
    end
  end
endmodule : irf_edge_detect

// file: verilog/irf_flag_reg.sv
// sticky request flags, set by hardware, cleared only by written zeros
`timescale 1ns/1ps
module irf_flag_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] IMPL = '1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] set_evt,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] flags
);
  logic [W-1:0] clr;

  // a written 0 clears, a written 1 is ignored
  assign clr = wr_en ? ~wr_data : '0;

  // set wins over a clear in the same cycle; nothing else clears
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags <= '0;
    end else begin
      flags <= ((flags & ~clr) | set_evt) & IMPL;
    end
  end
endmodule : irf_flag_reg

// file: verilog/irf_params.svh
// offsets, field positions, reset values and bus answers of the request flag block
`ifndef IRF_PARAMS_SVH
`define IRF_PARAMS_SVH

// register byte offsets
`define IRF_OFF_PIN_FLAGS 8'h00
`define IRF_OFF_PERIPH_FLAGS 8'h04
`define IRF_OFF_PIN_CONFIG 8'h08
`define IRF_OFF_SYS_CTRL_TWO 8'h0c
`define IRF_OFF_IRQ_STATUS 8'h10
`define IRF_OFF_IRQ_MASK 8'h14

// pin flag register fields
`define IRF_BIT_TIMER_A 7
`define IRF_BIT_PIN_RSVD 5
`define IRF_BIT_PIN4 4
`define IRF_BIT_PIN3 3
`define IRF_BIT_EVT_PIN 2
`define IRF_BIT_PIN1 1
`define IRF_BIT_PIN0 0
`define IRF_PIN_IMPL 8'h9f
`define IRF_PIN_RSVD_ONES 8'h20

// peripheral flag register fields
`define IRF_BIT_DIRECT 7
`define IRF_BIT_ADC 6
`define IRF_BIT_TIMER_G 4
`define IRF_BIT_TIMER_FH 3
`define IRF_BIT_TIMER_FL 2
`define IRF_BIT_TIMER_C 1
`define IRF_BIT_EVT_CNT 0
`define IRF_PERIPH_IMPL 8'hdf

// pin configuration fields: designation in [4:0], edge select in [12:8]
`define IRF_CFG_DESIG_LSB 0
`define IRF_CFG_EDGE_LSB 8
`define IRF_BIT_DT_ENABLE 0

// reset values
`define IRF_RST_FLAGS 8'h00
`define IRF_RST_CFG 5'h00
`define IRF_RST_WORD 32'h0000_0000

// bus answers
`define IRF_RESP_OKAY 2'h0
`define IRF_RESP_SLVERR 2'h2

`endif

// file: verilog/irf_pkg.sv
// types shared by the request flag block
package irf_pkg;
  typedef logic [7:0] irf_flags_t;
  typedef logic [1:0] irf_resp_t;
  typedef logic [4:0] irf_pins_t;
  typedef enum {
    IRF_SEL_PIN,
    IRF_SEL_PERIPH,
    IRF_SEL_CFG,
    IRF_SEL_SYS,
    IRF_SEL_STAT,
    IRF_SEL_MASK,
    IRF_SEL_NONE
  } irf_reg_sel_t;
endpackage : irf_pkg

// file: verilog/irf_top.sv
// request flag registers with their AXI4-Lite slave and summary interrupt
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "irf_params.svh"
module irf_top import irf_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // request pins: [4]=pin4 [3]=pin3 [2]=evt_counter_request_pin [1]=pin1 [0]=pin0
  input wire logic [4:0] ext_pins,
  // peripheral event pulses, plus the conversion in-progress level
  input wire logic timer_a_overflow,
  input wire logic timer_g_event,
  input wire logic timer_fh_event,
  input wire logic timer_fl_event,
  input wire logic timer_c_event,
  input wire logic evt_counter_overflow,
  input wire logic sleep_exec,
  input wire logic direct_mode_transfer,
  input wire logic conversion_in_progress,
  // flag views for the interrupt unit and summary interrupt
  output logic [7:0] pin_request_flags,
  output logic [7:0] peripheral_request_flags,
  output logic irq
);
  // software-owned control
  irf_pins_t pin_designated;
  irf_pins_t pin_rising;
  logic direct_transfer_enable;
  logic [15:0] irq_status;
  logic [15:0] irq_mask;

  // write channel holding state
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_go;
  irf_reg_sel_t wr_sel;
  irf_reg_sel_t rd_sel;

  // hardware events
  irf_pins_t pin_evt;
  logic adc_done_evt;
  logic [0:0] adc_fall;
  irf_flags_t pin_set;
  irf_flags_t periph_set;
  irf_flags_t pin_flags;
  irf_flags_t periph_flags;
  logic pin_wr;
  logic periph_wr;
  logic stat_rd_clr;
  logic [31:0] next_rdata;
  logic [15:0] next_irq_status;

  // word offset decode shared by both channels
  function automatic irf_reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] off;
    off = {{(8 - 1){1'b0}}, 1'b0} | 8'(addr);
    off[1:0] = 2'h0;
    case (off)
      `IRF_OFF_PIN_FLAGS: decode = IRF_SEL_PIN;
      `IRF_OFF_PERIPH_FLAGS: decode = IRF_SEL_PERIPH;
      `IRF_OFF_PIN_CONFIG: decode = IRF_SEL_CFG;
      `IRF_OFF_SYS_CTRL_TWO: decode = IRF_SEL_SYS;
      `IRF_OFF_IRQ_STATUS: decode = IRF_SEL_STAT;
      `IRF_OFF_IRQ_MASK: decode = IRF_SEL_MASK;
      default: decode = IRF_SEL_NONE;
    endcase
  endfunction : decode

  // ------------------------------------------------------------------
  // event detection
  // ------------------------------------------------------------------

  // pin edges, gated by designation; undesignated pins never raise a flag
  irf_edge_detect #(
    .W(5)
  ) u_pin_edges (
    .clk(clk),
    .rstn(rstn),
    .level(ext_pins),
    .rising_sel(pin_rising),
    .designated(pin_designated),
    .evt(pin_evt)
  );

  // conversion done is the falling edge of the in-progress bit
  irf_edge_detect #(
    .W(1)
  ) u_adc_done (
    .clk(clk),
    .rstn(rstn),
    .level(conversion_in_progress),
    .rising_sel(1'b0),
    .designated(1'b1),
    .evt(adc_fall)
  );
  assign adc_done_evt = adc_fall[0];

  // pin flag set vector, reserved bits 6 and 5 never set
  always_comb begin
    pin_set = `IRF_RST_FLAGS;
    pin_set[`IRF_BIT_TIMER_A] = timer_a_overflow;
    pin_set[`IRF_BIT_PIN4] = pin_evt[4];
    pin_set[`IRF_BIT_PIN3] = pin_evt[3];
    pin_set[`IRF_BIT_EVT_PIN] = pin_evt[2];
    pin_set[`IRF_BIT_PIN1] = pin_evt[1];
    pin_set[`IRF_BIT_PIN0] = pin_evt[0];
  end

  // peripheral flag set vector in register bit order
  always_comb begin
    periph_set = `IRF_RST_FLAGS;
    periph_set[`IRF_BIT_DIRECT] =
      sleep_exec & direct_transfer_enable & direct_mode_transfer;
    periph_set[`IRF_BIT_ADC] = adc_done_evt;
    periph_set[`IRF_BIT_TIMER_G] = timer_g_event;
    periph_set[`IRF_BIT_TIMER_FH] = timer_fh_event;
    periph_set[`IRF_BIT_TIMER_FL] = timer_fl_event;
    periph_set[`IRF_BIT_TIMER_C] = timer_c_event;
    periph_set[`IRF_BIT_EVT_CNT] = evt_counter_overflow;
  end

  // ------------------------------------------------------------------
  // flag registers
  // ------------------------------------------------------------------

  assign wr_sel = decode(wr_addr);
  assign pin_wr = wr_go & (wr_sel == IRF_SEL_PIN) & wr_strb[0];
  assign periph_wr = wr_go & (wr_sel == IRF_SEL_PERIPH) & wr_strb[0];

  // only implemented bits exist, so writes to bit 5 do nothing
  irf_flag_reg #(
    .W(8),
    .IMPL(`IRF_PIN_IMPL)
  ) u_pin_flags (
    .clk(clk),
    .rstn(rstn),
    .set_evt(pin_set),
    .wr_en(pin_wr),
    .wr_data(wr_data[7:0]),
    .flags(pin_flags)
  );

  // reserved bit 5 is not stored; a 1 written there is simply dropped
  irf_flag_reg #(
    .W(8),
    .IMPL(`IRF_PERIPH_IMPL)
  ) u_periph_flags (
    .clk(clk),
    .rstn(rstn),
    .set_evt(periph_set),
    .wr_en(periph_wr),
    .wr_data(wr_data[7:0]),
    .flags(periph_flags)
  );

  // flag views to the interrupt unit, registered copies of the flags
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_request_flags <= `IRF_PIN_RSVD_ONES;
      peripheral_request_flags <= `IRF_RST_FLAGS;
    end else begin
      pin_request_flags <= pin_flags | `IRF_PIN_RSVD_ONES;
      peripheral_request_flags <= periph_flags;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------------

  // address and data are taken independently; write happens once both are held
  assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      wr_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wr_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_wready <= 1'b1;
      wr_data <= `IRF_RST_WORD;
      wr_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // response one cycle after both halves are held; unmapped gives SLVERR
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IRF_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == IRF_SEL_NONE) ? `IRF_RESP_SLVERR : `IRF_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // pin designation and edge select, byte lanes 0 and 1
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_designated <= `IRF_RST_CFG;
      pin_rising <= `IRF_RST_CFG;
    end else if (wr_go && wr_sel == IRF_SEL_CFG) begin
      if (wr_strb[0]) begin
        pin_designated <= wr_data[`IRF_CFG_DESIG_LSB +: 5];
      end
      if (wr_strb[1]) begin
        pin_rising <= wr_data[`IRF_CFG_EDGE_LSB +: 5];
      end
    end
  end

  // direct transfer enable control bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      direct_transfer_enable <= 1'b0;
    end else if (wr_go && wr_sel == IRF_SEL_SYS && wr_strb[0]) begin
      direct_transfer_enable <= wr_data[`IRF_BIT_DT_ENABLE];
    end
  end

  // interrupt mask, same layout as the status word
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_mask <= 16'h0000;
    end else if (wr_go && wr_sel == IRF_SEL_MASK) begin
      if (wr_strb[0]) begin
        irq_mask[7:0] <= wr_data[7:0];
      end
      if (wr_strb[1]) begin
        irq_mask[15:8] <= wr_data[15:8];
      end
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------------

  assign rd_sel = decode(s_axi_araddr);
  assign stat_rd_clr = s_axi_arvalid & s_axi_arready & (rd_sel == IRF_SEL_STAT);

  // read data mux; reserved bits read as zero except pin bit 5
  always_comb begin
    next_rdata = `IRF_RST_WORD;
    case (rd_sel)
      IRF_SEL_PIN: next_rdata[7:0] = pin_flags | `IRF_PIN_RSVD_ONES;
      IRF_SEL_PERIPH: next_rdata[7:0] = periph_flags;
      IRF_SEL_CFG: begin
        next_rdata[`IRF_CFG_DESIG_LSB +: 5] = pin_designated;
        next_rdata[`IRF_CFG_EDGE_LSB +: 5] = pin_rising;
      end
      IRF_SEL_SYS: next_rdata[`IRF_BIT_DT_ENABLE] = direct_transfer_enable;
      IRF_SEL_STAT: next_rdata[15:0] = irq_status;
      IRF_SEL_MASK: next_rdata[15:0] = irq_mask;
      default: next_rdata = `IRF_RST_WORD;
    endcase
  end

  // one read at a time; arready drops while the answer is outstanding
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `IRF_RST_WORD;
      s_axi_rresp <= `IRF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= (rd_sel == IRF_SEL_NONE) ? `IRF_RESP_SLVERR : `IRF_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // summary interrupt
  // ------------------------------------------------------------------

  // status catches every set event; a read clears it, but a new event wins
  always_comb begin
    next_irq_status = stat_rd_clr ? 16'h0000 : irq_status;
    next_irq_status = next_irq_status | {periph_set, pin_set};
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_status <= 16'h0000;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // level output from a flop; the request flags themselves are untouched by it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, wr_data[31:16], wr_strb[3:2]};
endmodule : irf_top
